/* File: hdl/sflash_id_status.sv */
// Serial flash command front end: id reads, status read and status bits
`timescale 1ns/1ps
module sflash_id_status #(
    parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEV_DENSITY = 8'h4d, // Arbitrary value
    parameter int NUM_BLOCKS = 32
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    input wire logic array_done,
    output logic so,
    output logic so_oe,
    output logic array_start,
    output logic [2:0] array_op,
    output logic [23:0] array_addr,
    output logic [7:0] flash_status,
    output logic protect_top_bottom
);
    // ---------------- Link domain (sclk, decoder cleared by deselect) ----------------
    sflash_pkg::link_state_e lst_q, lst_d; // Decode state
    logic [2:0] bit_q, bit_d; // Bit within byte
    logic [6:0] sh_q, sh_d; // Input shift
    logic [1:0] cnt_q, cnt_d; // Address byte count
    logic [1:0] idx_q, idx_d; // Output byte index
    logic [7:0] hold_q, hold_d; // Status copy for this byte
    // Command record, kept after deselect for the core to sample
    sflash_pkg::req_kind_e kind_q, kind_d;
    logic [15:0] wdata_q, wdata_d; // Status write data
    logic [23:0] addr_q, addr_d; // Collected address
    logic [1:0] nb_q, nb_d; // Whole data bytes received
    logic aligned_q, aligned_d; // Last edge closed a byte
    logic tog_q, tog_d; // Flips once per frame
    logic seen_q, seen_d; // Core copy of the last frame toggle acted on
    logic [7:0] ssync1_q, ssync2_q; // Status level synchroniser
    logic [7:0] in_byte; // Byte completing on this edge
    logic byte_done;
    logic [7:0] out_byte; // Byte being shifted out
    logic out_bit;
    logic out_en;

    // Next state of the link decoder
    always_comb begin
        in_byte = {sh_q, si};
        byte_done = (bit_q == 3'h7);
        lst_d = lst_q;
        bit_d = bit_q + 3'h1;
        sh_d = in_byte[6:0];
        cnt_d = cnt_q;
        idx_d = idx_q;
        hold_d = byte_done ? ssync2_q : hold_q;
        kind_d = kind_q;
        wdata_d = wdata_q;
        addr_d = addr_q;
        nb_d = nb_q;
        aligned_d = byte_done;
        tog_d = tog_q;
        case (lst_q)
            sflash_pkg::L_CMD: begin
                // First edge of a frame starts a fresh record
                if (bit_q == 3'h0) begin
                    // Seen_q only moves between frames, so it is quiet here
                    tog_d = ~seen_q;
                    kind_d = sflash_pkg::K_NONE;
                end
                if (byte_done) begin
                    cnt_d = 2'h0;
                    idx_d = 2'h0;
                    case (in_byte)
                        sflash_pkg::OP_MAKER_DEV: begin
                            lst_d = sflash_pkg::L_ADDR;
                        end
                        sflash_pkg::OP_TRIPLET: begin
                            // Busy array: opcode not decoded
                            lst_d = ssync2_q[sflash_pkg::ST_BUSY] ?
                                sflash_pkg::L_IGNORE : sflash_pkg::L_TRIPLET_OUT;
                        end
                        sflash_pkg::OP_STATUS: begin
                            lst_d = sflash_pkg::L_STATUS_OUT;
                        end
                        sflash_pkg::OP_SET_LATCH: begin
                            kind_d = sflash_pkg::K_SET_LATCH;
                            lst_d = sflash_pkg::L_IGNORE;
                        end
                        sflash_pkg::OP_CLR_LATCH: begin
                            kind_d = sflash_pkg::K_CLR_LATCH;
                            lst_d = sflash_pkg::L_IGNORE;
                        end
                        sflash_pkg::OP_WSTATUS: begin
                            kind_d = sflash_pkg::K_WSTATUS;
                            nb_d = 2'h0;
                            lst_d = sflash_pkg::L_WDATA;
                        end
                        sflash_pkg::OP_PAGE_PROG: begin
                            kind_d = sflash_pkg::K_PAGE_PROG;
                            lst_d = sflash_pkg::L_ADDR;
                        end
                        sflash_pkg::OP_SECT_ERASE: begin
                            kind_d = sflash_pkg::K_SECT;
                            lst_d = sflash_pkg::L_ADDR;
                        end
                        sflash_pkg::OP_BLOCK_ERASE: begin
                            kind_d = sflash_pkg::K_BLOCK;
                            lst_d = sflash_pkg::L_ADDR;
                        end
                        sflash_pkg::OP_CHIP_ERASE: begin
                            kind_d = sflash_pkg::K_CHIP;
                            lst_d = sflash_pkg::L_IGNORE;
                        end
                        default: begin
                            lst_d = sflash_pkg::L_IGNORE; // Unknown opcode
                        end
                    endcase
                end
            end
            sflash_pkg::L_ADDR: begin
                // Two dummies then the address byte, or a 3-byte address
                if (byte_done) begin
                    addr_d = {addr_q[15:0], in_byte};
                    cnt_d = cnt_q + 2'h1;
                    if (cnt_q == 2'h2) begin
                        idx_d = {1'b0, in_byte[0]};
                        lst_d = (kind_q == sflash_pkg::K_NONE) ?
                            sflash_pkg::L_MAKER_OUT : sflash_pkg::L_IGNORE;
                    end
                end
            end
            sflash_pkg::L_MAKER_OUT: begin
                if (byte_done) begin
                    idx_d = {1'b0, ~idx_q[0]};
                end
            end
            sflash_pkg::L_TRIPLET_OUT: begin
                if (byte_done) begin
                    idx_d = (idx_q == 2'h2) ? 2'h0 : idx_q + 2'h1;
                end
            end
            sflash_pkg::L_WDATA: begin
                // First byte is status, second is configuration
                if (byte_done) begin
                    if (nb_q == 2'h0) begin
                        wdata_d[7:0] = in_byte;
                    end else if (nb_q == 2'h1) begin
                        wdata_d[15:8] = in_byte;
                    end
                    nb_d = (nb_q == 2'h3) ? nb_q : nb_q + 2'h1;
                end
            end
            default: begin
                lst_d = lst_q; // Status out or ignore: nothing to decode
            end
        endcase
    end

    // Decoder registers, cleared whenever select is high
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            lst_q <= sflash_pkg::L_CMD;
            bit_q <= 3'h0;
            sh_q <= 7'h00;
            cnt_q <= 2'h0;
            idx_q <= 2'h0;
            hold_q <= 8'h00;
        end else begin
            lst_q <= lst_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            hold_q <= hold_d;
        end
    end

    // Command record, held across deselect
    always_ff @(posedge sclk) begin
        kind_q <= kind_d;
        wdata_q <= wdata_d;
        addr_q <= addr_d;
        nb_q <= nb_d;
        aligned_q <= aligned_d;
        tog_q <= tog_d;
        ssync1_q <= flash_status;
        ssync2_q <= ssync1_q;
    end

    // Byte to present on the serial output
    always_comb begin
        case (lst_q)
            sflash_pkg::L_MAKER_OUT: begin
                out_byte = idx_q[0] ? DEV_DENSITY : MAKER_ID;
                out_en = 1'b1;
            end
            sflash_pkg::L_TRIPLET_OUT: begin
                out_byte = (idx_q == 2'h0) ? MAKER_ID :
                    (idx_q == 2'h1) ? MEM_TYPE : DEV_DENSITY;
                out_en = 1'b1;
            end
            sflash_pkg::L_STATUS_OUT: begin
                out_byte = hold_q;
                out_en = 1'b1;
            end
            default: begin
                out_byte = 8'h00;
                out_en = 1'b0;
            end
        endcase
        out_bit = out_byte[~bit_q];
    end

    // Output driven on falling clock, released on deselect
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            so <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so <= out_bit;
            so_oe <= out_en;
        end
    end

    // ---------------- Core domain (core_clk) ----------------
    logic cs1_q, cs2_q, cs3_q, cs_lvl_q, cs_lvl_d; // Select synchroniser
    logic wp1_q, wp2_q, wp3_q, wp_lvl_q, wp_lvl_d; // Protect pin synchroniser
    logic busy_q, busy_d;
    logic latch_q, latch_d;
    logic [3:0] prot_q, prot_d;
    logic quad_q, quad_d;
    logic lock_q, lock_d;
    logic topbot_q, topbot_d;
    logic wact_q, wact_d; // Status write timer running
    logic [11:0] wcnt_q, wcnt_d;
    logic start_d;
    logic [2:0] op_d;
    logic [23:0] aaddr_d;
    logic frame_end;
    logic new_frame;
    logic hw_prot;

    // True when the block holding addr is inside the protected area
    function automatic logic in_prot(input logic [23:0] a, input logic [3:0] bp,
                                     input logic bottom);
        logic [6:0] size;
        logic [6:0] blk;
        size = (bp == 4'h0) ? 7'h00 :
            (bp > 4'h6) ? 7'(NUM_BLOCKS) : (7'h01 << (bp - 4'h1));
        if (size > 7'(NUM_BLOCKS)) begin
            size = 7'(NUM_BLOCKS);
        end
        blk = {2'b00, a[20:16]};
        in_prot = bottom ? (blk < size) : (blk >= 7'(NUM_BLOCKS) - size);
    endfunction

    // Next values of the status bits and array requests
    always_comb begin
        cs_lvl_d = (cs2_q == cs3_q) ? cs3_q : cs_lvl_q;
        wp_lvl_d = (wp2_q == wp3_q) ? wp3_q : wp_lvl_q;
        frame_end = cs2_q && cs3_q && !cs_lvl_q;
        new_frame = frame_end && (tog_q != seen_q);
        seen_d = frame_end ? tog_q : seen_q;
        hw_prot = lock_q && !wp_lvl_q && !quad_q;
        busy_d = busy_q;
        latch_d = latch_q;
        prot_d = prot_q;
        quad_d = quad_q;
        lock_d = lock_q;
        topbot_d = topbot_q;
        wact_d = wact_q;
        wcnt_d = wcnt_q;
        start_d = 1'b0;
        op_d = array_op;
        aaddr_d = array_addr;
        if (busy_q) begin
            // Running operation ends, latch drops; commands framed meanwhile are dropped
            if (wact_q) begin
                wcnt_d = wcnt_q - 12'h001;
                if (wcnt_q == 12'h001) begin
                    busy_d = 1'b0;
                    wact_d = 1'b0;
                    latch_d = 1'b0;
                end
            end else if (array_done) begin
                busy_d = 1'b0;
                latch_d = 1'b0;
            end
        end else if (new_frame && aligned_q) begin
            case (kind_q)
                sflash_pkg::K_SET_LATCH: begin
                    latch_d = 1'b1;
                end
                sflash_pkg::K_CLR_LATCH: begin
                    latch_d = 1'b0;
                end
                sflash_pkg::K_WSTATUS: begin
                    // Needs latch, no pin lock, 8 or 16 data bits
                    if (latch_q && !hw_prot && (nb_q == 2'h1 || nb_q == 2'h2)) begin
                        prot_d = wdata_q[sflash_pkg::ST_PROT_LO +: 4];
                        quad_d = wdata_q[sflash_pkg::ST_QUAD];
                        lock_d = wdata_q[sflash_pkg::ST_LOCK];
                        if (nb_q == 2'h2) begin
                            topbot_d = topbot_q | wdata_q[8 + sflash_pkg::CFG_TOPBOT];
                        end
                        busy_d = 1'b1;
                        wact_d = 1'b1;
                        wcnt_d = sflash_pkg::WSTAT_CYCLES;
                    end
                end
                sflash_pkg::K_PAGE_PROG, sflash_pkg::K_SECT, sflash_pkg::K_BLOCK: begin
                    if (latch_q && !in_prot(addr_q, prot_q, topbot_q)) begin
                        start_d = 1'b1;
                        busy_d = 1'b1;
                        op_d = kind_q;
                        aaddr_d = addr_q;
                    end
                end
                sflash_pkg::K_CHIP: begin
                    if (latch_q && prot_q == 4'h0) begin
                        start_d = 1'b1;
                        busy_d = 1'b1;
                        op_d = kind_q;
                        aaddr_d = 24'h000000;
                    end
                end
                default: begin
                    busy_d = busy_q; // Reads need no core action
                end
            endcase
        end
    end

    // Core registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            // Synchronisers start at the idle pin level, no false edge
            cs1_q <= 1'b1;
            cs2_q <= 1'b1;
            cs3_q <= 1'b1;
            wp1_q <= 1'b1;
            wp2_q <= 1'b1;
            wp3_q <= 1'b1;
            cs_lvl_q <= 1'b1;
            wp_lvl_q <= 1'b1;
            seen_q <= 1'b0;
            busy_q <= 1'b0;
            latch_q <= 1'b0;
            prot_q <= sflash_pkg::PROT_RESET;
            quad_q <= sflash_pkg::QUAD_RESET;
            lock_q <= sflash_pkg::LOCK_RESET;
            topbot_q <= sflash_pkg::TOPBOT_RESET;
            wact_q <= 1'b0;
            wcnt_q <= 12'h000;
            array_start <= 1'b0;
            array_op <= 3'h0;
            array_addr <= 24'h000000;
            flash_status <= 8'h00;
            protect_top_bottom <= 1'b0;
        end else begin
            cs1_q <= cs_n;
            cs2_q <= cs1_q;
            cs3_q <= cs2_q;
            wp1_q <= wp_n;
            wp2_q <= wp1_q;
            wp3_q <= wp2_q;
            cs_lvl_q <= cs_lvl_d;
            wp_lvl_q <= wp_lvl_d;
            seen_q <= seen_d;
            busy_q <= busy_d;
            latch_q <= latch_d;
            prot_q <= prot_d;
            quad_q <= quad_d;
            lock_q <= lock_d;
            topbot_q <= topbot_d;
            wact_q <= wact_d;
            wcnt_q <= wcnt_d;
            array_start <= start_d;
            array_op <= op_d;
            array_addr <= aaddr_d;
            flash_status <= {lock_d, quad_d, prot_d, latch_d, busy_d};
            protect_top_bottom <= topbot_d;
        end
    end
endmodule

/* File: shared/sflash_pkg.sv */
// Constants, opcodes and state codes for the serial flash id/status block
package sflash_pkg;
    // Command opcodes
    localparam logic [7:0] OP_MAKER_DEV = 8'h90;
    localparam logic [7:0] OP_TRIPLET = 8'h9f;
    localparam logic [7:0] OP_STATUS = 8'h05;
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_WSTATUS = 8'h01;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_SECT_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
    // Status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_PROT_LO = 2;
    localparam int ST_QUAD = 6;
    localparam int ST_LOCK = 7;
    localparam int CFG_TOPBOT = 3;
    // Reset values of the non-volatile fields
    localparam logic [3:0] PROT_RESET = 4'h0;
    localparam logic QUAD_RESET = 1'b0;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic TOPBOT_RESET = 1'b0;
    // Self-timed status write, rounded up to whole cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam int WSTAT_TIME_NS = 1000;
    localparam logic [11:0] WSTAT_CYCLES =
        12'((WSTAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Link-side decode states
    typedef enum logic [2:0] {
        L_CMD = 3'b000,
        L_ADDR = 3'b001,
        L_MAKER_OUT = 3'b010,
        L_TRIPLET_OUT = 3'b011,
        L_STATUS_OUT = 3'b100,
        L_WDATA = 3'b101,
        L_IGNORE = 3'b110
    } link_state_e;
    // Command kinds handed to the core side
    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_SET_LATCH = 3'b001,
        K_CLR_LATCH = 3'b010,
        K_WSTATUS = 3'b011,
        K_PAGE_PROG = 3'b100,
        K_SECT = 3'b101,
        K_BLOCK = 3'b110,
        K_CHIP = 3'b111
    } req_kind_e;
endpackage

/* File: dv/sflash_id_status_properties.sv */
// Port-level checks on the serial flash id/status block
`timescale 1ns/1ps
module sflash_id_status_properties #(
    parameter int NUM_BLOCKS = 32
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    input wire logic array_done,
    input wire logic so,
    input wire logic so_oe,
    input wire logic array_start,
    input wire logic [2:0] array_op,
    input wire logic [23:0] array_addr,
    input wire logic [7:0] flash_status,
    input wire logic protect_top_bottom
);
    // All checks sample on the core clock
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_reset_status_zero: assert property ($fell(reset) |-> flash_status == 8'h00)
        else $error("status not clear after reset");
    a_oe_off_desel: assert property (cs_n |-> !so_oe)
        else $error("output driven while deselected");
    a_start_needs_latch: assert property (array_start |->
        $past(flash_status[1]) && !$past(flash_status[0]))
        else $error("operation started without latch or while busy");
    a_start_sets_busy: assert property (array_start |-> ##[0:2] flash_status[0])
        else $error("busy flag not raised by operation");
    a_busy_end_latch: assert property ($fell(flash_status[0]) |-> !flash_status[1])
        else $error("latch still set when busy cleared");
    a_chip_erase_clear: assert property (array_start && array_op == 3'h7 |->
        $past(flash_status[5:2]) == 4'h0)
        else $error("chip erase started with protect bits set");
    a_prot_only_wstat: assert property ($changed(flash_status[7:2]) |->
        (flash_status[0] || $past(flash_status[0])) or ##1 flash_status[0])
        else $error("protect bits changed outside a status write");
    a_topbot_oneway: assert property (protect_top_bottom |=> protect_top_bottom)
        else $error("selector returned to zero");
    a_hw_lock_holds: assert property ((flash_status[7] && !flash_status[6] && !wp_n)
        [*6] |=> $stable(flash_status[7:2]))
        else $error("locked bits changed under pin protection");
endmodule

/* File: dv/spi_host_model.sv */
// Host controller model framing mode 0 serial transfers
`timescale 1ns/1ps
module spi_host_model (
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic [7:0] rx_byte; // Last byte taken from the device
    logic oe_seen; // Device drove its output in this frame
    event got; // Fires when a checked byte lands
    // Idle link: clock still, select high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx_byte = 8'h00;
        oe_seen = 1'b0;
    end
    // Select with clock low
    task automatic sel();
        oe_seen = 1'b0;
        cs_n = 1'b0;
        #16;
    endtask
    // One byte MSB first; both sides sample on the rise
    task automatic xbyte(input logic [7:0] tx, input bit chk);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #16 sclk = 1'b1;
            rx_byte[i] = (so_oe === 1'b1) ? so : ~so; // Released line reads inverted
            if (so_oe === 1'b1) oe_seen = 1'b1;
            #16 sclk = 1'b0;
        end
        if (chk) ->got;
    endtask
    // Deselect; data line wanders once released
    task automatic desel();
        #16 cs_n = 1'b1;
        si = ~si;
        #100;
    endtask
    // Poll until busy and latch both read zero
    task automatic poll_idle();
        logic [7:0] st;
        st = 8'hff;
        for (int n = 0; n < 400 && st[1:0] !== 2'b00; n++) begin
            sel();
            xbyte(8'h05, 1'b0);
            xbyte(8'h00, 1'b0);
            st = rx_byte;
            desel();
        end
    endtask
endmodule

/* File: dv/sflash_id_status_tb.sv */
// Self-checking bench for the serial flash id/status block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module sflash_id_status_tb;
    localparam logic [7:0] MK = 8'ha7; // Arbitrary value
    localparam logic [7:0] TY = 8'h61; // Arbitrary value
    localparam logic [7:0] DN = 8'h3e; // Arbitrary value
    logic core_clk, reset, wp_n, array_done, sclk, cs_n, si, so, so_oe;
    logic array_start, protect_top_bottom;
    logic [2:0] array_op;
    logic [23:0] array_addr;
    logic [7:0] flash_status, e;
    logic [26:0] o;
    int err_total = 0;
    int total_checks = 0;
    int seed;
    logic [7:0] exp_rx[$]; // Expected link bytes
    logic [26:0] exp_op[$]; // Expected accepted operations
    // Core clock, 10 ns
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    sflash_id_status #(.MAKER_ID(MK), .MEM_TYPE(TY), .DEV_DENSITY(DN), .NUM_BLOCKS(32)) DUT (
        .core_clk(core_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n),
        .array_done(array_done), .so(so), .so_oe(so_oe), .array_start(array_start),
        .array_op(array_op), .array_addr(array_addr), .flash_status(flash_status),
        .protect_top_bottom(protect_top_bottom));
    spi_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
    // Oldest link note against each checked byte
    always @(host.got) begin
        e = (exp_rx.size() > 0) ? exp_rx.pop_front() : 8'hxx;
        `CHK("link byte", e, host.rx_byte)
    end
    // Oldest operation note against each start pulse
    always @(negedge core_clk) begin
        if (array_start === 1'b1) begin
            o = (exp_op.size() > 0) ? exp_op.pop_front() : 27'hx;
            `CHK("array op", o[26:24], array_op)
            if (o[26:24] != 3'h7) `CHK("array addr", o[23:0], array_addr)
        end
    end
    // Whole command frame, replies ignored
    task automatic frame(input logic [7:0] b[$]);
        host.sel();
        foreach (b[i]) host.xbyte(b[i], 1'b0);
        host.desel();
    endtask
    // Status read of two repeated bytes
    task automatic rd_status(input logic [7:0] x);
        exp_rx.push_back(x);
        exp_rx.push_back(x);
        host.sel();
        host.xbyte(sflash_pkg::OP_STATUS, 1'b0);
        repeat (2) host.xbyte(8'($urandom), 1'b1);
        host.desel();
    endtask
    // Program or erase, noted when it must be taken
    task automatic op(input logic [7:0] c, input logic [2:0] k, input logic [23:0] a,
                      input bit ok);
        if (ok) exp_op.push_back({k, a});
        if (c == sflash_pkg::OP_CHIP_ERASE) frame({c});
        else frame({c, a[23:16], a[15:8], a[7:0]});
    endtask
    // Array engine reports completion
    task automatic finish_op();
        @(negedge core_clk) array_done = 1'b1;
        @(negedge core_clk) array_done = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        #500000;
        err_total++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        seed = $urandom(32'hd3c1);
        reset = 1'b1;
        wp_n = 1'b1;
        array_done = 1'b0;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        frame({8'h00});
        rd_status(8'h00);
        // Maker/device pair, both start orders
        for (int k = 0; k < 2; k++) begin
            for (int j = 0; j < 4; j++) exp_rx.push_back((j[0] ^ k[0]) ? DN : MK);
            host.sel();
            host.xbyte(sflash_pkg::OP_MAKER_DEV, 1'b0);
            repeat (2) host.xbyte(8'($urandom), 1'b0);
            host.xbyte(8'(k), 1'b0);
            repeat (4) host.xbyte(8'($urandom), 1'b1);
            host.desel();
        end
        // Triplet, wrapping, cut short
        exp_rx = {exp_rx, MK, TY, DN, MK};
        host.sel();
        host.xbyte(sflash_pkg::OP_TRIPLET, 1'b0);
        repeat (4) host.xbyte(8'($urandom), 1'b1);
        host.desel();
        frame({sflash_pkg::OP_SET_LATCH});
        rd_status(8'h02);
        frame({sflash_pkg::OP_CLR_LATCH});
        rd_status(8'h00);
        op(sflash_pkg::OP_PAGE_PROG, sflash_pkg::K_PAGE_PROG, 24'h000100, 1'b0);
        frame({sflash_pkg::OP_SET_LATCH});
        op(sflash_pkg::OP_PAGE_PROG, sflash_pkg::K_PAGE_PROG, {8'h00, 16'($urandom)}, 1'b1);
        rd_status(8'h03);
        frame({sflash_pkg::OP_TRIPLET, 8'h00});
        `CHK("id while busy", 1'b0, host.oe_seen)
        rd_status(8'h03);
        finish_op();
        rd_status(8'h00);
        // Top block protected
        frame({sflash_pkg::OP_SET_LATCH});
        frame({sflash_pkg::OP_WSTATUS, 8'h04});
        host.poll_idle();
        rd_status(8'h04);
        frame({sflash_pkg::OP_SET_LATCH});
        op(sflash_pkg::OP_PAGE_PROG, sflash_pkg::K_PAGE_PROG, 24'h1f0020, 1'b0);
        op(sflash_pkg::OP_CHIP_ERASE, sflash_pkg::K_CHIP, 24'h000000, 1'b0);
        rd_status(8'h06);
        op(sflash_pkg::OP_SECT_ERASE, sflash_pkg::K_SECT, {8'h02, 16'($urandom)}, 1'b1);
        finish_op();
        frame({sflash_pkg::OP_SET_LATCH});
        op(sflash_pkg::OP_BLOCK_ERASE, sflash_pkg::K_BLOCK, {8'h05, 16'($urandom)}, 1'b1);
        finish_op();
        // Lock, and move the area to the bottom
        frame({sflash_pkg::OP_SET_LATCH});
        frame({sflash_pkg::OP_WSTATUS, 8'h84, 8'h08});
        host.poll_idle();
        rd_status(8'h84);
        `CHK("selector", 1'b1, protect_top_bottom)
        frame({sflash_pkg::OP_SET_LATCH});
        op(sflash_pkg::OP_PAGE_PROG, sflash_pkg::K_PAGE_PROG, 24'h000010, 1'b0);
        op(sflash_pkg::OP_PAGE_PROG, sflash_pkg::K_PAGE_PROG, 24'h1f0010, 1'b1);
        finish_op();
        // Pin protection refuses status write
        @(negedge core_clk) wp_n = 1'b0;
        frame({sflash_pkg::OP_SET_LATCH});
        frame({sflash_pkg::OP_WSTATUS, 8'h00});
        rd_status(8'h86);
        @(negedge core_clk) wp_n = 1'b1;
        frame({sflash_pkg::OP_WSTATUS, 8'h00, 8'h00});
        host.poll_idle();
        rd_status(8'h00);
        `CHK("selector kept", 1'b1, protect_top_bottom)
        // Quad enable disables the pin lock
        frame({sflash_pkg::OP_SET_LATCH});
        frame({sflash_pkg::OP_WSTATUS, 8'hc4});
        host.poll_idle();
        @(negedge core_clk) wp_n = 1'b0;
        rd_status(8'hc4);
        frame({sflash_pkg::OP_SET_LATCH});
        frame({sflash_pkg::OP_WSTATUS, 8'h00});
        host.poll_idle();
        rd_status(8'h00);
        @(negedge core_clk) wp_n = 1'b1;
        frame({sflash_pkg::OP_SET_LATCH});
        op(sflash_pkg::OP_CHIP_ERASE, sflash_pkg::K_CHIP, 24'h000000, 1'b1);
        finish_op();
        rd_status(8'h00);
        `CHK("notes left", 0, exp_op.size() + exp_rx.size())
        tally_and_finish();
    end
endmodule
bind sflash_id_status sflash_id_status_properties #(.NUM_BLOCKS(NUM_BLOCKS)) chk_i (
    .core_clk(core_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .array_done(array_done), .so(so), .so_oe(so_oe), .array_start(array_start),
    .array_op(array_op), .array_addr(array_addr), .flash_status(flash_status),
    .protect_top_bottom(protect_top_bottom));
